/* File: hdl/spfcc_unit.sv */
/*
 * Single-precision convert, sign-inject, move, compare and classify datapath
 * with an AHB-Lite slave. Assumes the pipeline resolves dynamic rounding.
 */
// Behaviour
// RQ1: float to signed word or long, into the integer destination.
// RQ2: signed word or long integer to single-precision float.
// RQ3: unsigned variants of every conversion, same register roles.
// RQ4: word float-to-integer results sign-extended in the 64-bit base.
// RQ5: long conversions illegal outside the 64-bit base.
// RQ6: unrepresentable rounded results clipped, invalid raised.
// RQ7: negative overflow or -inf give the minimum; unsigned gives zero.
// RQ8: positive overflow, +inf or NaN give the destination maximum.
// RQ9: conversions round as round_select asks.
// RQ10: zero integer source converts to +0, no flags.
// RQ11: inexact when rounding changed the value and invalid is clear.
// RQ12: sign injection keeps first_source bits; sign by copy, negate or xor.
// RQ13: sign injection raises no flags, keeps NaN payloads.
// RQ14: float_to_int_bits copies the raw 32 bits into the low half.
// RQ15: 64-bit base: upper half repeats the float sign bit.
// RQ16: int_bits_to_float copies the low 32 integer bits unaltered.
// RQ17: compares write one when the condition holds, else zero.
// RQ18: less and less-equal raise invalid on any NaN.
// RQ19: equal raises invalid only on a signaling NaN.
// RQ20: compares return zero when either operand is NaN.
// RQ21: classify writes a 10-bit one-hot mask, other bits clear, no flags.
// RQ22: mask bits 0..9: -inf,-norm,-sub,-0,+0,+sub,+norm,+inf,sNaN,qNaN.
// RQ23: float results get all-ones upper bits when boxing is on.
// RQ24: badly boxed non-transfer inputs read as canonical NaN.
`timescale 1ns/1ns
`include "spfcc_consts.svh"

module spfcc_unit
	import spfcc_pkg::*;
(
	input  wire logic        core_clk_i,       // core clock, 100 MHz
	input  wire logic        rst_i,            // synchronous reset, active high
	input  wire logic        op_valid_i,       // operation issued this cycle
	input  wire spfcc_op_t   op_code_i,        // operation to perform
	input  wire logic [2:0]  round_select_i,   // resolved rounding select
	input  wire logic [63:0] int_first_i,      // integer first_source value
	input  wire logic [63:0] fp_first_i,       // float first_source register
	input  wire logic [63:0] fp_second_i,      // float second_source register
	output logic             res_valid_o,      // result valid, one cycle
	output logic             int_write_o,      // result goes to integer file
	output logic             fp_write_o,       // result goes to float file
	output logic [63:0]      result_o,         // result value
	output logic             flag_invalid_o,   // invalid flag of this result
	output logic             flag_inexact_o,   // inexact flag of this result
	output logic             illegal_o,        // operation not legal here
	input  wire logic        hsel_i,           // AHB-Lite slave select
	input  wire logic [31:0] haddr_i,          // AHB-Lite address
	input  wire logic [1:0]  htrans_i,         // AHB-Lite transfer type
	input  wire logic        hwrite_i,         // AHB-Lite write
	input  wire logic [2:0]  hsize_i,          // AHB-Lite size
	input  wire logic [31:0] hwdata_i,         // AHB-Lite write data
	input  wire logic        hready_i,         // AHB-Lite bus ready
	output logic [31:0]      hrdata_o,         // AHB-Lite read data
	output logic             hreadyout_o,      // AHB-Lite slave ready
	output logic             hresp_o           // AHB-Lite response
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic round_inc(input logic [2:0] rm, input logic sgn,
		input logic lsb, input logic grd, input logic stk);
		case (rm)
			`SPFCC_RM_RNE: round_inc = grd & (stk | lsb);
			`SPFCC_RM_RTZ: round_inc = 1'b0;
			`SPFCC_RM_RDN: round_inc = sgn & (grd | stk);
			`SPFCC_RM_RUP: round_inc = ~sgn & (grd | stk);
			`SPFCC_RM_RMM: round_inc = grd;
			default:       round_inc = grd & (stk | lsb);
		endcase
	endfunction

	function automatic logic [6:0] lead_zeros(input logic [63:0] v);
		logic found;
		lead_zeros = 7'd64;
		found      = 1'b0;
		for (int i = 63; i >= 0; i--)
		begin
			if (!found && v[i])
			begin
				lead_zeros = 7'(63 - i);
				found      = 1'b1;
			end
		end
	endfunction

	// ------------------------------------------------------------------
	// configuration and accrued flags
	// ------------------------------------------------------------------
	logic [1:0]  ctrl_reg;
	logic [1:0]  stat_reg;
	logic        base64;
	logic        box_en;

	assign base64 = ctrl_reg[`SPFCC_CTRL_BASE64_BIT];
	assign box_en = ctrl_reg[`SPFCC_CTRL_BOX_BIT];

	// ------------------------------------------------------------------
	// operand unboxing
	// ------------------------------------------------------------------
	logic [31:0] a;
	logic [31:0] b;

	// RQ24: boxing check
	assign a = (box_en && fp_first_i[63:32] != `SPFCC_BOX_ONES) ? `SPFCC_CANON_NAN : fp_first_i[31:0];
	assign b = (box_en && fp_second_i[63:32] != `SPFCC_BOX_ONES) ? `SPFCC_CANON_NAN : fp_second_i[31:0];

	logic a_nan;
	logic b_nan;
	logic a_snan;
	logic b_snan;
	logic a_inf;
	logic a_zero;
	logic b_zero;
	logic a_sub;

	assign a_nan  = (a[30:23] == 8'hff) && (a[22:0] != 23'h0);
	assign b_nan  = (b[30:23] == 8'hff) && (b[22:0] != 23'h0);
	assign a_snan = a_nan && !a[22];
	assign b_snan = b_nan && !b[22];
	assign a_inf  = (a[30:23] == 8'hff) && (a[22:0] == 23'h0);
	assign a_zero = (a[30:0] == 31'h0);
	assign b_zero = (b[30:0] == 31'h0);
	assign a_sub  = (a[30:23] == 8'h00) && !a_zero;

	// ------------------------------------------------------------------
	// float to integer
	// ------------------------------------------------------------------
	logic [23:0]  f2i_sig;
	logic [7:0]   f2i_sh;
	logic [127:0] f2i_fx;
	logic [63:0]  f2i_int;
	logic         f2i_grd;
	logic         f2i_stk;
	logic         f2i_big;
	logic [64:0]  f2i_mag;
	logic         f2i_ovf;
	logic         f2i_inv;
	logic [63:0]  f2i_raw;
	logic [63:0]  f2i_res;
	logic         f2i_long;
	logic         f2i_uns;

	assign f2i_long = (op_code_i == SPFCC_OP_F2SL) || (op_code_i == SPFCC_OP_F2UL);
	assign f2i_uns  = (op_code_i == SPFCC_OP_F2UW) || (op_code_i == SPFCC_OP_F2UL);
	assign f2i_sig  = {a[30:23] != 8'h00, a[22:0]};
	assign f2i_sh   = a[30:23] - `SPFCC_EXP_FIX_SHIFT;
	assign f2i_big  = a[30:23] >= `SPFCC_EXP_TOO_BIG;

	always_comb
	begin
		f2i_fx  = 128'h0;
		f2i_int = 64'h0;
		f2i_grd = 1'b0;
		f2i_stk = 1'b0;
		if (a[30:23] < `SPFCC_EXP_FIX_SHIFT)
			f2i_stk = !a_zero;
		else if (!f2i_big)
		begin
			f2i_fx  = {104'h0, f2i_sig} << f2i_sh;
			f2i_int = f2i_fx[127:64];
			f2i_grd = f2i_fx[63];
			f2i_stk = |f2i_fx[62:0];
		end
	end

	// RQ9: rounding of the integer magnitude
	assign f2i_mag = {1'b0, f2i_int} + {64'h0, round_inc(round_select_i, a[31], f2i_int[0], f2i_grd, f2i_stk)};

	// RQ6: range check against the destination type
	always_comb
	begin
		case ({f2i_long, f2i_uns})
			2'b00:   f2i_ovf = a[31] ? (f2i_mag > `SPFCC_LIM_SW_NEG) : (f2i_mag > `SPFCC_LIM_SW_POS);
			2'b01:   f2i_ovf = a[31] ? (f2i_mag != 65'h0) : (f2i_mag > `SPFCC_LIM_UW_POS);
			2'b10:   f2i_ovf = a[31] ? (f2i_mag > `SPFCC_LIM_SL_NEG) : (f2i_mag > `SPFCC_LIM_SL_POS);
			default: f2i_ovf = a[31] ? (f2i_mag != 65'h0) : (f2i_mag > `SPFCC_LIM_UL_POS);
		endcase
		f2i_ovf = f2i_ovf | f2i_big;
	end

	assign f2i_inv = a_nan | f2i_ovf;

	always_comb
	begin
		// RQ8: positive overflow, +inf and NaN clip to maximum
		if (a_nan || (f2i_ovf && !a[31]))
		begin
			case ({f2i_long, f2i_uns})
				2'b00:   f2i_raw = `SPFCC_MAX_SW;
				2'b01:   f2i_raw = `SPFCC_MAX_UW;
				2'b10:   f2i_raw = `SPFCC_MAX_SL;
				default: f2i_raw = `SPFCC_MAX_UL;
			endcase
		end
		// RQ7: negative overflow and -inf clip to minimum
		else if (f2i_ovf)
		begin
			case ({f2i_long, f2i_uns})
				2'b00:   f2i_raw = `SPFCC_MIN_SW;
				2'b10:   f2i_raw = `SPFCC_MIN_SL;
				default: f2i_raw = 64'h0;
			endcase
		end
		// RQ1: in-range signed or unsigned value
		else
			f2i_raw = a[31] ? (64'h0 - f2i_mag[63:0]) : f2i_mag[63:0];
		// RQ4: word results sign-extended in the 64-bit base
		if (f2i_long)
			f2i_res = f2i_raw;
		else if (base64)
			f2i_res = {{32{f2i_raw[31]}}, f2i_raw[31:0]};
		else
			f2i_res = {32'h0, f2i_raw[31:0]};
	end

	// ------------------------------------------------------------------
	// integer to float
	// ------------------------------------------------------------------
	logic [63:0] i2f_src;
	logic        i2f_sgn;
	logic [63:0] i2f_abs;
	logic [6:0]  i2f_lz;
	logic [63:0] i2f_norm;
	logic [24:0] i2f_sum;
	logic [7:0]  i2f_exp;
	logic [31:0] i2f_res;
	logic        i2f_inx;

	// RQ3: unsigned sources are zero-extended, signed ones sign-extended
	always_comb
	begin
		case (op_code_i)
			SPFCC_OP_SW2F: i2f_src = {{32{int_first_i[31]}}, int_first_i[31:0]};
			SPFCC_OP_UW2F: i2f_src = {32'h0, int_first_i[31:0]};
			default:       i2f_src = int_first_i;
		endcase
		i2f_sgn = (op_code_i == SPFCC_OP_SW2F || op_code_i == SPFCC_OP_SL2F) && i2f_src[63];
	end

	assign i2f_abs  = i2f_sgn ? (64'h0 - i2f_src) : i2f_src;
	assign i2f_lz   = lead_zeros(i2f_abs);
	assign i2f_norm = i2f_abs << i2f_lz[5:0];
	// RQ9: round the 24-bit significand
	assign i2f_sum  = {1'b0, i2f_norm[63:40]}
		+ {24'h0, round_inc(round_select_i, i2f_sgn, i2f_norm[40], i2f_norm[39], |i2f_norm[38:0])};
	assign i2f_exp  = `SPFCC_I2F_EXP_TOP - {1'b0, i2f_lz} + {7'h0, i2f_sum[24]};
	assign i2f_inx  = i2f_norm[39] | (|i2f_norm[38:0]);

	// RQ2: pack sign, exponent and rounded fraction
	// RQ10: a zero source gives +0 with no flags
	always_comb
	begin
		if (i2f_abs == 64'h0)
			i2f_res = 32'h0;
		else if (i2f_sum[24])
			i2f_res = {i2f_sgn, i2f_exp, 23'h0};
		else
			i2f_res = {i2f_sgn, i2f_exp, i2f_sum[22:0]};
	end

	// ------------------------------------------------------------------
	// compares and classification
	// ------------------------------------------------------------------
	logic        cmp_eq;
	logic        cmp_lt;
	logic [9:0]  cls_mask;

	// +0 equals -0; NaN handled per operation
	assign cmp_eq = (a == b) || (a_zero && b_zero);
	always_comb
	begin
		if (a[31] != b[31])
			cmp_lt = a[31] && !(a_zero && b_zero);
		else if (a[31])
			cmp_lt = a[30:0] > b[30:0];
		else
			cmp_lt = a[30:0] < b[30:0];
	end

	// RQ22: one class bit per value category
	always_comb
	begin
		cls_mask    = 10'h0;
		cls_mask[0] = a_inf && a[31];
		cls_mask[1] = a[31] && !a_nan && !a_inf && !a_zero && !a_sub;
		cls_mask[2] = a_sub && a[31];
		cls_mask[3] = a_zero && a[31];
		cls_mask[4] = a_zero && !a[31];
		cls_mask[5] = a_sub && !a[31];
		cls_mask[6] = !a[31] && !a_nan && !a_inf && !a_zero && !a_sub;
		cls_mask[7] = a_inf && !a[31];
		cls_mask[8] = a_snan;
		cls_mask[9] = a_nan && !a_snan;
	end

	// ------------------------------------------------------------------
	// result selection
	// ------------------------------------------------------------------
	logic [63:0] res_next;
	logic        int_wr_next;
	logic        fp_wr_next;
	logic        inv_next;
	logic        inx_next;
	logic        ill_next;
	logic [31:0] fp_val;

	always_comb
	begin
		res_next    = 64'h0;
		fp_val      = 32'h0;
		int_wr_next = 1'b0;
		fp_wr_next  = 1'b0;
		inv_next    = 1'b0;
		inx_next    = 1'b0;
		ill_next    = 1'b0;
		case (op_code_i)
			SPFCC_OP_F2SW, SPFCC_OP_F2SL, SPFCC_OP_F2UW, SPFCC_OP_F2UL:
			begin
				int_wr_next = 1'b1;
				res_next    = f2i_res;
				inv_next    = f2i_inv;
				// RQ11: inexact only when invalid is clear
				inx_next    = !f2i_inv && (f2i_grd || f2i_stk);
			end
			SPFCC_OP_SW2F, SPFCC_OP_SL2F, SPFCC_OP_UW2F, SPFCC_OP_UL2F:
			begin
				fp_wr_next = 1'b1;
				fp_val     = i2f_res;
				inx_next   = i2f_inx;
			end
			// RQ12: sign injection variants
			// RQ13: no flags, payload untouched
			SPFCC_OP_COPY_SIGN:
			begin
				fp_wr_next = 1'b1;
				fp_val     = {b[31], a[30:0]};
			end
			SPFCC_OP_NEG_SIGN:
			begin
				fp_wr_next = 1'b1;
				fp_val     = {~b[31], a[30:0]};
			end
			SPFCC_OP_XOR_SIGN:
			begin
				fp_wr_next = 1'b1;
				fp_val     = {a[31] ^ b[31], a[30:0]};
			end
			// RQ14: raw pattern, no unboxing
			// RQ15: upper half from the sign bit
			SPFCC_OP_F2I_BITS:
			begin
				int_wr_next = 1'b1;
				res_next    = base64 ? {{32{fp_first_i[31]}}, fp_first_i[31:0]} : {32'h0, fp_first_i[31:0]};
			end
			// RQ16: raw low integer bits
			SPFCC_OP_I2F_BITS:
			begin
				fp_wr_next = 1'b1;
				fp_val     = int_first_i[31:0];
			end
			// RQ17: single-bit compare result
			// RQ20: NaN forces zero
			// RQ19: quiet equal
			SPFCC_OP_CMP_EQ:
			begin
				int_wr_next = 1'b1;
				res_next    = {63'h0, cmp_eq && !a_nan && !b_nan};
				inv_next    = a_snan || b_snan;
			end
			// RQ18: signaling less and less-equal
			SPFCC_OP_CMP_LT:
			begin
				int_wr_next = 1'b1;
				res_next    = {63'h0, cmp_lt && !a_nan && !b_nan};
				inv_next    = a_nan || b_nan;
			end
			SPFCC_OP_CMP_LE:
			begin
				int_wr_next = 1'b1;
				res_next    = {63'h0, (cmp_lt || cmp_eq) && !a_nan && !b_nan};
				inv_next    = a_nan || b_nan;
			end
			// RQ21: mask in low bits, rest clear, no flags
			SPFCC_OP_CLASSIFY:
			begin
				int_wr_next = 1'b1;
				res_next    = {54'h0, cls_mask};
			end
			default:
				ill_next = 1'b1;
		endcase
		// RQ23: box single results into the wide register
		if (fp_wr_next)
			res_next = box_en ? {`SPFCC_BOX_ONES, fp_val} : {32'h0, fp_val};
		// RQ5: long conversions only in the 64-bit base
		if (!base64 && op_code_i inside {SPFCC_OP_F2SL, SPFCC_OP_F2UL, SPFCC_OP_SL2F, SPFCC_OP_UL2F})
			ill_next = 1'b1;
		// unsupported rounding codes are refused rather than guessed
		if (round_select_i > `SPFCC_RM_RMM && op_code_i inside {[SPFCC_OP_F2SW:SPFCC_OP_UL2F]})
			ill_next = 1'b1;
		if (ill_next)
		begin
			res_next    = 64'h0;
			int_wr_next = 1'b0;
			fp_wr_next  = 1'b0;
			inv_next    = 1'b0;
			inx_next    = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// result stage
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			res_valid_o    <= 1'b0;
			int_write_o    <= 1'b0;
			fp_write_o     <= 1'b0;
			result_o       <= 64'h0;
			flag_invalid_o <= 1'b0;
			flag_inexact_o <= 1'b0;
			illegal_o      <= 1'b0;
		end
		else
		begin
			res_valid_o    <= op_valid_i;
			int_write_o    <= op_valid_i & int_wr_next;
			fp_write_o     <= op_valid_i & fp_wr_next;
			result_o       <= res_next;
			flag_invalid_o <= op_valid_i & inv_next;
			flag_inexact_o <= op_valid_i & inx_next;
			illegal_o      <= op_valid_i & ill_next;
		end
	end

	// ------------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ------------------------------------------------------------------
	logic        wr_pend_reg;
	logic [11:0] wr_addr_reg;
	logic        acc_take;

	assign acc_take    = hsel_i && htrans_i[1] && hready_i;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h0;
			hrdata_o    <= 32'h0;
		end
		else
		begin
			wr_pend_reg <= acc_take && hwrite_i && (hsize_i == 3'h2) && haddr_i[31:12] == 20'h0;
			wr_addr_reg <= haddr_i[11:0];
			// read data is sampled in the address phase and shown in the data phase
			if (acc_take && !hwrite_i)
			begin
				if (haddr_i[31:12] != 20'h0)
					hrdata_o <= 32'h0;
				else if (haddr_i[11:0] == `SPFCC_CTRL_OFF)
					hrdata_o <= {30'h0, ctrl_reg};
				else if (haddr_i[11:0] == `SPFCC_STAT_OFF)
					hrdata_o <= {30'h0, stat_reg};
				else
					hrdata_o <= 32'h0;
			end
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			ctrl_reg <= `SPFCC_CTRL_RST;
		else if (wr_pend_reg && wr_addr_reg == `SPFCC_CTRL_OFF)
			ctrl_reg <= hwdata_i[1:0];
	end

	// accrued flags: write one to clear, a new flag in the same cycle wins
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			stat_reg <= 2'h0;
		else
		begin
			stat_reg <= (stat_reg & ~((wr_pend_reg && wr_addr_reg == `SPFCC_STAT_OFF) ? hwdata_i[1:0] : 2'h0))
				| {flag_inexact_o, flag_invalid_o};
		end
	end

endmodule

/* File: hdl/spfcc_consts.svh */
/*
 * Convert/compare unit constants: offsets, fields, resets, rounding, limits.
 * Assumes inclusion by bare name.
 */
`ifndef SPFCC_CONSTS_SVH
`define SPFCC_CONSTS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses on the bus)
// ----------------------------------------------------------------------
`define SPFCC_CTRL_OFF        12'h000
`define SPFCC_STAT_OFF        12'h004
`define SPFCC_CTRL_BASE64_BIT 0
`define SPFCC_CTRL_BOX_BIT    1
`define SPFCC_CTRL_RST        2'h3
`define SPFCC_STAT_INV_BIT    0
`define SPFCC_STAT_INX_BIT    1

// ----------------------------------------------------------------------
// rounding select encodings
// ----------------------------------------------------------------------
`define SPFCC_RM_RNE          3'h0
`define SPFCC_RM_RTZ          3'h1
`define SPFCC_RM_RDN          3'h2
`define SPFCC_RM_RUP          3'h3
`define SPFCC_RM_RMM          3'h4

// ----------------------------------------------------------------------
// float encodings and conversion limits
// ----------------------------------------------------------------------
`define SPFCC_CANON_NAN       32'h7fc00000
`define SPFCC_BOX_ONES        32'hffffffff
`define SPFCC_EXP_BIAS        8'h7f
`define SPFCC_EXP_FIX_SHIFT   8'h56
`define SPFCC_EXP_TOO_BIG     8'hbf
`define SPFCC_I2F_EXP_TOP     8'hbe
`define SPFCC_LIM_SW_POS      65'h0_0000_0000_7fff_ffff
`define SPFCC_LIM_SW_NEG      65'h0_0000_0000_8000_0000
`define SPFCC_LIM_UW_POS      65'h0_0000_0000_ffff_ffff
`define SPFCC_LIM_SL_POS      65'h0_7fff_ffff_ffff_ffff
`define SPFCC_LIM_SL_NEG      65'h0_8000_0000_0000_0000
`define SPFCC_LIM_UL_POS      65'h0_ffff_ffff_ffff_ffff
`define SPFCC_MAX_SW          64'h0000_0000_7fff_ffff
`define SPFCC_MIN_SW          64'h0000_0000_8000_0000
`define SPFCC_MAX_UW          64'h0000_0000_ffff_ffff
`define SPFCC_MAX_SL          64'h7fff_ffff_ffff_ffff
`define SPFCC_MIN_SL          64'h8000_0000_0000_0000
`define SPFCC_MAX_UL          64'hffff_ffff_ffff_ffff

`endif

/* File: hdl/spfcc_pkg.sv */
/*
 * Convert/compare unit types.
 * Assumes the pipeline decodes the opcode.
 */
package spfcc_pkg;

	typedef enum logic [4:0]
	{
		SPFCC_OP_NONE,
		SPFCC_OP_F2SW,
		SPFCC_OP_F2SL,
		SPFCC_OP_F2UW,
		SPFCC_OP_F2UL,
		SPFCC_OP_SW2F,
		SPFCC_OP_SL2F,
		SPFCC_OP_UW2F,
		SPFCC_OP_UL2F,
		SPFCC_OP_COPY_SIGN,
		SPFCC_OP_NEG_SIGN,
		SPFCC_OP_XOR_SIGN,
		SPFCC_OP_F2I_BITS,
		SPFCC_OP_I2F_BITS,
		SPFCC_OP_CMP_EQ,
		SPFCC_OP_CMP_LT,
		SPFCC_OP_CMP_LE,
		SPFCC_OP_CLASSIFY
	} spfcc_op_t;

endpackage

/* File: verification/spfcc_unit_asserts.sv */
/* operation-port assertions of the convert/compare unit.
   assumes binding onto spfcc_unit; one result per issue. */
`timescale 1ns/1ns
module spfcc_unit_asserts
	import spfcc_pkg::*;
(
	input wire logic        core_clk_i,     // clock
	input wire logic        rst_i,          // reset
	input wire logic        op_valid_i,     // issue
	input wire spfcc_op_t   op_code_i,      // operation
	input wire logic [63:0] int_first_i,    // int source
	input wire logic [63:0] fp_first_i,     // fp source 1
	input wire logic [63:0] fp_second_i,    // fp source 2
	input wire logic        res_valid_o,    // result valid
	input wire logic [63:0] result_o,       // result
	input wire logic        flag_invalid_o, // invalid
	input wire logic        flag_inexact_o  // inexact
);
	// ------------------------------
	// nan tests on the raw low word; a bad box shows only in boxed, not as nan
	// ------------------------------
	wire logic nan_a = &fp_first_i[30:23] && |fp_first_i[22:0];
	wire logic nan_b = &fp_second_i[30:23] && |fp_second_i[22:0];
	wire logic snan_a = nan_a && !fp_first_i[22];
	wire logic snan_b = nan_b && !fp_second_i[22];
	wire logic boxed = &fp_first_i[63:32] && &fp_second_i[63:32];

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_op(spfcc_op_t c);
		op_valid_i && op_code_i == c;
	endsequence
	sequence s_cmp;
		s_op(SPFCC_OP_CMP_EQ) or s_op(SPFCC_OP_CMP_LT) or s_op(SPFCC_OP_CMP_LE);
	endsequence

	a_res_next:
		assert property (op_valid_i |=> res_valid_o) else $error("no result after issue");
	a_sgn_quiet:
		assert property ((s_op(SPFCC_OP_COPY_SIGN) or s_op(SPFCC_OP_NEG_SIGN) or s_op(SPFCC_OP_XOR_SIGN))
			|=> !flag_invalid_o && !flag_inexact_o) else $error("sign injection raised a flag");
	a_cmp_bool:
		assert property (s_cmp |=> result_o[63:1] == 63'h0 && !flag_inexact_o) else $error("compare not 0/1");
	a_ord_nan:
		assert property (op_valid_i && op_code_i inside {SPFCC_OP_CMP_LT, SPFCC_OP_CMP_LE}
			&& (nan_a || nan_b) |=> flag_invalid_o && result_o == 64'h0) else $error("ordered nan compare");
	a_eq_quiet:
		assert property (op_valid_i && op_code_i == SPFCC_OP_CMP_EQ && boxed && !snan_a && !snan_b
			|=> !flag_invalid_o) else $error("equal compare not quiet");
	a_class_hot:
		assert property (s_op(SPFCC_OP_CLASSIFY) |=> $onehot(result_o[9:0]) && result_o[63:10] == 54'h0
			&& !flag_invalid_o) else $error("classify mask wrong");
	a_raw_out:
		assert property (s_op(SPFCC_OP_F2I_BITS) |=> result_o[31:0] == $past(fp_first_i[31:0]))
			else $error("bit move out altered");
	a_raw_in:
		assert property (s_op(SPFCC_OP_I2F_BITS) |=> result_o[31:0] == $past(int_first_i[31:0]))
			else $error("bit move in altered");
	a_flag_excl:
		assert property (res_valid_o |-> !(flag_invalid_o && flag_inexact_o)) else $error("both flags set");
endmodule

bind spfcc_unit spfcc_unit_asserts u_chk
(
	.core_clk_i(core_clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
	.int_first_i(int_first_i), .fp_first_i(fp_first_i), .fp_second_i(fp_second_i), .res_valid_o(res_valid_o),
	.result_o(result_o), .flag_invalid_o(flag_invalid_o), .flag_inexact_o(flag_inexact_o)
);

/* File: verification/spfcc_pipe_model.sv */
/* pipeline model: issues one operation over the taking edge.
   assumes the unit answers on the next edge. */
`timescale 1ns/1ns
module spfcc_pipe_model
	import spfcc_pkg::*;
(
	input  wire logic   clk_i, // core clock
	output logic        vld_o, // issue
	output spfcc_op_t   op_o,  // operation
	output logic [2:0]  rm_o,  // rounding
	output logic [63:0] int_o, // int source
	output logic [63:0] fa_o,  // fp source 1
	output logic [63:0] fb_o   // fp source 2
);
	initial
	begin
		{vld_o, rm_o, int_o, fa_o, fb_o} = '0;
		op_o = SPFCC_OP_NONE;
	end

	task issue(input spfcc_op_t c, input logic [2:0] r, input logic [63:0] i, a, b);
		@(posedge clk_i);
		{vld_o, rm_o, int_o, fa_o, fb_o} <= {1'b1, r, i, a, b};
		op_o <= c;
		@(posedge clk_i);
		vld_o <= 1'b0;
		// stale sources are inverted so nothing leans on them
		{int_o, fa_o, fb_o} <= ~{i, a, b};
		#1;
	endtask
endmodule

/* File: verification/tb_sp_float_convert_compare_unit.sv */
/* self-checking bench of the convert/compare unit.
   assumes the pipeline model drives the operation port. */
`timescale 1ns/1ns
module tb_sp_float_convert_compare_unit
	import spfcc_pkg::*;
;
	localparam logic [63:0] Z = 64'h0;
	logic        core_clk, rst, hsel, hwrite, hready, hresp;
	logic        vld, res_vld, int_wr, fp_wr, f_inv, f_inx, ill;
	logic [1:0]  htrans;
	logic [2:0]  hsize, rm;
	logic [31:0] haddr, hwdata, hrdata, rd, x, y;
	logic [63:0] src_i, src_a, src_b, res;
	spfcc_op_t   opc;
	integer      n_fail, comparisons, cyc, seed, k, j;
	logic [31:0] ca [5] = '{32'h3f800000, 32'h40000000, 32'h7fc00000, 32'h7f800001, 32'h80000000};
	logic [31:0] cb [5] = '{32'h40000000, 32'h40000000, 32'h3f800000, 32'h3f800000, 32'h00000000};
	logic [2:0]  cr [5] = '{3'h3, 3'h5, 3'h0, 3'h0, 3'h5};
	logic [31:0] cl [10] = '{32'hff800000, 32'hbf800000, 32'h80000001, 32'h80000000, 32'h0,
		32'h1, 32'h3f800000, 32'h7f800000, 32'h7f800001, 32'h7fc00000};

	spfcc_unit dut
	(
		.core_clk_i(core_clk), .rst_i(rst), .op_valid_i(vld), .op_code_i(opc), .round_select_i(rm),
		.int_first_i(src_i), .fp_first_i(src_a), .fp_second_i(src_b), .res_valid_o(res_vld),
		.int_write_o(int_wr), .fp_write_o(fp_wr), .result_o(res), .flag_invalid_o(f_inv),
		.flag_inexact_o(f_inx), .illegal_o(ill), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp)
	);
	spfcc_pipe_model m
	(
		.clk_i(core_clk), .vld_o(vld), .op_o(opc), .rm_o(rm), .int_o(src_i), .fa_o(src_a), .fb_o(src_b)
	);

	function automatic logic [63:0] bx(input logic [31:0] v);
		bx = {32'hffffffff, v};
	endfunction
	function automatic logic [31:0] sgnj(input integer s, input logic [31:0] a, b);
		sgnj = {s == 0 ? b[31] : s == 1 ? ~b[31] : a[31] ^ b[31], a[30:0]};
	endfunction

	task end_sim;
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [63:0] g, e);
		comparisons = comparisons + 1;
		if (g !== e)
		begin
			n_fail = n_fail + 1;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// fl holds illegal, invalid, inexact
	task op(input spfcc_op_t c, input logic [2:0] r, input logic [63:0] i, a, b, e, input logic [2:0] fl);
		m.issue(c, r, i, a, b);
		chk(res, e);
		chk({res_vld, ill, f_inv, f_inx, hresp, int_wr ^ fp_wr, fp_wr},
			{1'b1, fl, 1'b0, !fl[2], !fl[2] && c inside {[SPFCC_OP_SW2F:SPFCC_OP_XOR_SIGN], SPFCC_OP_I2F_BITS}});
	endtask
	task ahb(input logic w, input logic [31:0] a, d);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ceiling far above the cycles the tests need
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_fail = n_fail + 1;
			$display("unexpected at %0t: timeout", $time);
			end_sim;
		end
	end

	initial
	begin
		{seed, n_fail, comparisons, cyc} = {32'd7, 96'd0};
		{rst, hsel, hwrite, htrans, hsize, haddr, hwdata} = {5'h10, 3'h2, 64'h0};
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		ahb(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h3);
		ahb(1'b0, 32'h8, 32'h0);
		chk(rd, 32'h0);
		op(SPFCC_OP_F2SW, 3'h0, Z, bx(32'hff800000), Z, 64'hffffffff80000000, 3'h2);
		op(SPFCC_OP_F2SW, 3'h0, Z, bx(32'h4f000000), Z, 64'h7fffffff, 3'h2);
		op(SPFCC_OP_F2UW, 3'h0, Z, bx(32'hc0a00000), Z, Z, 3'h2);
		op(SPFCC_OP_F2UW, 3'h7, Z, bx(32'h3f800000), Z, Z, 3'h4);
		op(SPFCC_OP_F2UW, 3'h0, Z, bx(32'h7f800000), Z, '1, 3'h2);
		op(SPFCC_OP_F2SL, 3'h0, Z, bx(32'h7fc00000), Z, 64'h7fffffffffffffff, 3'h2);
		op(SPFCC_OP_F2SL, 3'h0, Z, bx(32'hd3800000), Z, 64'hffffff0000000000, 3'h0);
		op(SPFCC_OP_UW2F, 3'h0, 64'hffffffff, Z, Z, bx(32'h4f800000), 3'h1);
		op(SPFCC_OP_UL2F, 3'h1, '1, Z, Z, bx(32'h5f7fffff), 3'h1);
		op(SPFCC_OP_F2I_BITS, 3'h0, Z, 64'hff812345, Z, 64'hffffffffff812345, 3'h0);
		op(SPFCC_OP_I2F_BITS, 3'h0, 64'h123456787f800001, Z, Z, bx(32'h7f800001), 3'h0);
		op(SPFCC_OP_CLASSIFY, 3'h0, Z, 64'h3f800000, Z, 64'h200, 3'h0);
		op(SPFCC_OP_NEG_SIGN, 3'h0, Z, bx(32'h7f800001), Z, bx(32'hff800001), 3'h0);
		for (k = 0; k < 5; k++)
		begin
			op(SPFCC_OP_F2SW, k[2:0], Z, bx(32'h40200000), Z, 64'(2 + (k == 3 || k == 4)), 3'h1);
			op(SPFCC_OP_F2SW, k[2:0], Z, bx(32'hc0200000), Z, -64'(2 + (k == 2 || k == 4)), 3'h1);
			op(SPFCC_OP_SL2F, k[2:0], 64'h1000001, Z, Z, bx(32'h4b800000 + (k == 3 || k == 4)), 3'h1);
			op(SPFCC_OP_SW2F, k[2:0], Z, Z, Z, bx(32'h0), 3'h0);
			for (j = 0; j < 3; j++)
				op(spfcc_op_t'(SPFCC_OP_CMP_EQ + j), 3'h0, Z, bx(ca[k]), bx(cb[k]), 64'(cr[k][2 - j]),
					{1'b0, k == 3 || (k == 2 && j > 0), 1'b0});
		end
		for (k = 0; k < 10; k++)
			op(SPFCC_OP_CLASSIFY, 3'h0, Z, bx(cl[k]), Z, 64'h1 << k, 3'h0);
		for (k = 0; k < 30; k++)
		begin
			x = $random(seed);
			y = $random(seed);
			op(spfcc_op_t'(SPFCC_OP_COPY_SIGN + k % 3), 3'h0, Z, bx(x), bx(y), bx(sgnj(k % 3, x, y)), 3'h0);
		end
		ahb(1'b0, 32'h4, 32'h0);
		chk(rd, 32'h3);
		ahb(1'b1, 32'h4, 32'h3);
		ahb(1'b0, 32'h4, 32'h0);
		chk(rd, 32'h0);
		// 32-bit base with boxing off
		ahb(1'b1, 32'h0, 32'h0);
		op(SPFCC_OP_F2SL, 3'h0, Z, Z, Z, Z, 3'h4);
		op(SPFCC_OP_UL2F, 3'h0, Z, Z, Z, Z, 3'h4);
		op(SPFCC_OP_F2SW, 3'h0, Z, 64'hff800000, Z, 64'h80000000, 3'h2);
		op(SPFCC_OP_F2I_BITS, 3'h0, Z, 64'hff812345, Z, 64'hff812345, 3'h0);
		op(SPFCC_OP_SW2F, 3'h0, 64'hffffffff, Z, Z, 64'hbf800000, 3'h0);
		end_sim;
	end
endmodule
